// [common/ssp_map.vh]
// Register map, reset values and timing constants of the sensor serial port
`ifndef SSP_MAP_VH
`define SSP_MAP_VH

// Register addresses
`define SSP_ADDR_MOTION_STATUS   7'h02
`define SSP_ADDR_Y_DISP          7'h03
`define SSP_ADDR_X_DISP          7'h04
`define SSP_ADDR_SURF_QUAL       7'h05
`define SSP_ADDR_SHUT_HI         7'h06
`define SSP_ADDR_SHUT_LO         7'h07
`define SSP_ADDR_MAX_PIXEL       7'h08
`define SSP_ADDR_SETUP_BITS      7'h11
`define SSP_ADDR_INIT_CMD        7'h3a
`define SSP_ADDR_BURST           7'h42

// Field positions
`define SSP_DIR_BIT              7
`define SSP_MOT_BIT              7
`define SSP_OVF_BIT              4
`define SSP_REST_BIT             7

// Reset values
`define SSP_SETUP_RST            8'h03
`define SSP_MOTION_RST           8'h00
`define SSP_INIT_KEY             8'h5a

// Burst length in bytes
`define SSP_BURST_LEN            3'h7

// Burst exit time in ns and its cycle count at 10 ns per clock
`define SSP_BURST_EXIT_NS        500
`define SSP_CLK_NS               10
`define SSP_BURST_EXIT_CYC       ((`SSP_BURST_EXIT_NS + `SSP_CLK_NS - 1) / `SSP_CLK_NS)

`endif

// [src/ssp_out_buf.v]
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module ssp_out_buf
(
	// Clock and reset
	input  wire       clk_sys_i,
	input  wire       rst_i,
	input  wire       flush_i,
	// Fill side
	input  wire       in_valid_i,
	output wire       in_ready_o,
	input  wire [7:0] in_data_i,
	// Drain side
	output wire       out_valid_o,
	input  wire       out_ready_i,
	output wire [7:0] out_data_o
);

reg  [7:0] mem_r [0:1];
reg        wptr_r;
reg        rptr_r;
reg  [1:0] cnt_r;
reg  [7:0] dout_r;
wire       push;
wire       pop;

assign in_ready_o  = (cnt_r != 2'd2);
assign out_valid_o = (cnt_r != 2'd0);
assign out_data_o  = dout_r;
assign push        = in_valid_i & in_ready_o;
assign pop         = out_valid_o & out_ready_i;

always @(posedge clk_sys_i or posedge rst_i)
begin
	if (rst_i)
	begin
		wptr_r    <= 1'b0;
		rptr_r    <= 1'b0;
		cnt_r     <= 2'd0;
		mem_r[0]  <= 8'h00;
		mem_r[1]  <= 8'h00;
	end
	else if (flush_i)
	begin
		wptr_r <= 1'b0;
		rptr_r <= 1'b0;
		cnt_r  <= 2'd0;
	end
	else
	begin
		if (push)
		begin
			mem_r[wptr_r] <= in_data_i;
			wptr_r        <= ~wptr_r;
		end
		if (pop)
			rptr_r <= ~rptr_r;
		case ({push, pop})
			2'b10:   cnt_r <= cnt_r + 2'd1;
			2'b01:   cnt_r <= cnt_r - 2'd1;
			default: cnt_r <= cnt_r;
		endcase
	end
end

// Read data from a register: head entry, or incoming word when empty; written slot's old word on push with pop at one entry
always @(posedge clk_sys_i or posedge rst_i)
begin
	if (rst_i)
		dout_r <= 8'h00;
	else if (push && (cnt_r == 2'd0 || (cnt_r == 2'd1 && pop)))
		dout_r <= (cnt_r == 2'd0) ? in_data_i : mem_r[~rptr_r];
	else if (pop)
		dout_r <= mem_r[~rptr_r];
end

endmodule

// [src/ssp_core.v]
// Serial port slave of the motion sensor with registers and burst readout
`timescale 1ns/1ps
`include "ssp_map.vh"
module ssp_core
(
	// Clock and reset
	input  wire       clk_sys_i,
	input  wire       rst_i,
	// Serial pins
	input  wire       sclk_i,
	input  wire       mosi_i,
	input  wire       port_select_n_i,
	output wire       miso_o,
	output wire       miso_oe_o,
	// Power-down pin
	input  wire       power_down_pin_i,
	// Motion datapath side
	input  wire       motion_event_i,
	input  wire       overflow_event_i,
	input  wire [7:0] delta_y_i,
	input  wire [7:0] delta_x_i,
	input  wire [7:0] surface_quality_reg_i,
	input  wire [7:0] shutter_hi_i,
	input  wire [7:0] shutter_lo_i,
	input  wire [7:0] max_pixel_i,
	// Status outputs
	output wire       motion_n_o,
	output wire       rest_mode_o,
	output wire       initialised_o,
	output wire       illum_drive_o
);

////////////////////////////////////////////////////////////////////////////////
// Input synchronisers and edge detection

reg  [1:0] sclk_s_r;
reg  [1:0] mosi_s_r;
reg  [1:0] sel_s_r;
reg  [1:0] pd_s_r;
reg        sclk_d_r;
reg        sel_d_r;

always @(posedge clk_sys_i or posedge rst_i)
begin
	if (rst_i)
	begin
		sclk_s_r <= 2'b00;
		mosi_s_r <= 2'b00;
		sel_s_r  <= 2'b11;
		pd_s_r   <= 2'b00;
		sclk_d_r <= 1'b0;
		sel_d_r  <= 1'b1;
	end
	else
	begin
		sclk_s_r <= {sclk_s_r[0], sclk_i};
		mosi_s_r <= {mosi_s_r[0], mosi_i};
		sel_s_r  <= {sel_s_r[0], port_select_n_i};
		pd_s_r   <= {pd_s_r[0], power_down_pin_i};
		sclk_d_r <= sclk_s_r[1];
		sel_d_r  <= sel_s_r[1];
	end
end

wire sel_n   = sel_s_r[1];
wire pd      = pd_s_r[1];
wire active  = ~sel_n & ~pd;
wire sck_ris = active & sclk_s_r[1] & ~sclk_d_r;
wire sck_fal = active & ~sclk_s_r[1] & sclk_d_r;
wire sel_ris = sel_n & ~sel_d_r;

////////////////////////////////////////////////////////////////////////////////
// Transaction state machine

localparam [4:0] ST_ADDR  = 5'b00001;
localparam [4:0] ST_WDATA = 5'b00010;
localparam [4:0] ST_RDATA = 5'b00100;
localparam [4:0] ST_BURST = 5'b01000;
localparam [4:0] ST_LOCK  = 5'b10000;

reg  [4:0] state_r;
reg  [4:0] state_nxt;
reg  [2:0] bit_cnt_r;
reg  [7:0] shin_r;
reg  [7:0] shout_r;
reg  [6:0] addr_r;
reg  [2:0] bytes_r;
reg        miso_r;
reg  [9:0] exit_cnt_r;
reg        init_r;
reg  [7:0] setup_r;
reg        mot_r;
reg        ovf_r;
reg  [7:0] rd_data;
reg        wr_stb;
reg        rd_y_r;
reg        rd_x_r;

wire [7:0] shin_nxt = {shin_r[6:0], mosi_s_r[1]};
wire       byte_end = sck_ris & (bit_cnt_r == 3'd7);

// Burst buffer path
wire       buf_in_ready;
wire       buf_out_valid;
wire [7:0] buf_out_data;
reg        buf_in_valid;
reg  [7:0] buf_in_data;
reg  [2:0] fill_idx_r;
reg        filling_r;
wire       buf_pop = (state_r == ST_BURST) & sck_fal & (bit_cnt_r == 3'd0);

always @*
begin
	case (addr_r)
		`SSP_ADDR_MOTION_STATUS: rd_data = {mot_r, 2'b00, ovf_r, 4'h0};
		`SSP_ADDR_Y_DISP:        rd_data = delta_y_i;
		`SSP_ADDR_X_DISP:        rd_data = delta_x_i;
		`SSP_ADDR_SURF_QUAL:     rd_data = surface_quality_reg_i;
		`SSP_ADDR_SHUT_HI:       rd_data = shutter_hi_i;
		`SSP_ADDR_SHUT_LO:       rd_data = shutter_lo_i;
		`SSP_ADDR_MAX_PIXEL:     rd_data = max_pixel_i;
		`SSP_ADDR_SETUP_BITS:    rd_data = setup_r;
		default:                 rd_data = 8'h00;
	endcase
end

always @*
begin
	case (fill_idx_r)
		3'd0:    buf_in_data = {mot_r, 2'b00, ovf_r, 4'h0};
		3'd1:    buf_in_data = delta_y_i;
		3'd2:    buf_in_data = delta_x_i;
		3'd3:    buf_in_data = surface_quality_reg_i;
		3'd4:    buf_in_data = shutter_hi_i;
		3'd5:    buf_in_data = shutter_lo_i;
		default: buf_in_data = max_pixel_i;
	endcase
	buf_in_valid = filling_r & active;
end

always @*
begin
	state_nxt = state_r;
	case (state_r)
		ST_ADDR:
			if (byte_end)
			begin
				if (shin_nxt[`SSP_DIR_BIT])
					state_nxt = ST_WDATA;
				else if (shin_nxt[6:0] == `SSP_ADDR_BURST)
					state_nxt = ST_BURST;
				else
					state_nxt = ST_RDATA;
			end
		ST_WDATA:
			if (byte_end)
				state_nxt = ST_ADDR;
		ST_RDATA:
			if (byte_end)
				state_nxt = ST_ADDR;
		ST_BURST:
			if (byte_end && bytes_r == `SSP_BURST_LEN - 3'd1)
				state_nxt = ST_LOCK;
		ST_LOCK:
			state_nxt = ST_LOCK;
		default:
			state_nxt = ST_ADDR;
	endcase
end

wire exit_done = (exit_cnt_r >= `SSP_BURST_EXIT_CYC);

always @(posedge clk_sys_i or posedge rst_i)
begin
	if (rst_i)
	begin
		state_r    <= ST_ADDR;
		bit_cnt_r  <= 3'd0;
		shin_r     <= 8'h00;
		shout_r    <= 8'h00;
		addr_r     <= 7'h00;
		bytes_r    <= 3'd0;
		miso_r     <= 1'b0;
		exit_cnt_r <= 10'd0;
		fill_idx_r <= 3'd0;
		filling_r  <= 1'b0;
		wr_stb     <= 1'b0;
	end
	else
	begin
		wr_stb <= 1'b0;
		if (sel_n && (state_r == ST_BURST || state_r == ST_LOCK))
		begin
			// Burst ends only after select has stayed high long enough
			exit_cnt_r <= exit_done ? exit_cnt_r : exit_cnt_r + 10'd1;
			if (exit_done)
			begin
				state_r   <= ST_ADDR;
				filling_r <= 1'b0;
			end
		end
		else if (sel_n || pd)
		begin
			state_r    <= (state_r == ST_BURST || state_r == ST_LOCK) ? state_r : ST_ADDR;
			exit_cnt_r <= 10'd0;
			bit_cnt_r  <= 3'd0;
			shin_r     <= 8'h00;
			filling_r  <= 1'b0;
		end
		else
		begin
			exit_cnt_r <= 10'd0;
			if (state_r != ST_LOCK)
			begin
				state_r <= state_nxt;
				if (sck_ris)
				begin
					shin_r    <= shin_nxt;
					bit_cnt_r <= bit_cnt_r + 3'd1;
				end
			end
			if (byte_end && state_r == ST_ADDR)
			begin
				addr_r <= shin_nxt[6:0];
				if (!shin_nxt[`SSP_DIR_BIT] && shin_nxt[6:0] == `SSP_ADDR_BURST)
				begin
					filling_r  <= 1'b1;
					fill_idx_r <= 3'd0;
					bytes_r    <= 3'd0;
				end
			end
			if (byte_end && state_r == ST_WDATA)
				wr_stb <= 1'b1;
			if (byte_end && state_r == ST_BURST)
				bytes_r <= bytes_r + 3'd1;
			if (filling_r && buf_in_ready)
			begin
				fill_idx_r <= fill_idx_r + 3'd1;
				if (fill_idx_r == `SSP_BURST_LEN - 3'd1)
					filling_r <= 1'b0;
			end
			if (sck_fal)
			begin
				if (state_r == ST_RDATA && bit_cnt_r == 3'd0)
				begin
					miso_r  <= rd_data[7];
					shout_r <= {rd_data[6:0], 1'b0};
				end
				else if (buf_pop)
				begin
					miso_r  <= buf_out_valid ? buf_out_data[7] : 1'b0;
					shout_r <= {buf_out_data[6:0], 1'b0};
				end
				else if (state_r == ST_RDATA || state_r == ST_BURST)
				begin
					miso_r  <= shout_r[7];
					shout_r <= {shout_r[6:0], 1'b0};
				end
			end
		end
	end
end

ssp_out_buf u_buf
(
	.clk_sys_i   (clk_sys_i),
	.rst_i       (rst_i),
	.flush_i     (sel_ris),
	.in_valid_i  (buf_in_valid),
	.in_ready_o  (buf_in_ready),
	.in_data_i   (buf_in_data),
	.out_valid_o (buf_out_valid),
	.out_ready_i (buf_pop),
	.out_data_o  (buf_out_data)
);

////////////////////////////////////////////////////////////////////////////////
// Registers and motion flag

always @(posedge clk_sys_i or posedge rst_i)
begin
	if (rst_i)
	begin
		setup_r <= `SSP_SETUP_RST;
		init_r  <= 1'b0;
		mot_r   <= 1'b0;
		ovf_r   <= 1'b0;
		rd_y_r  <= 1'b0;
		rd_x_r  <= 1'b0;
	end
	else
	begin
		if (wr_stb && addr_r == `SSP_ADDR_SETUP_BITS && init_r)
			setup_r <= shin_r;
		if (wr_stb && addr_r == `SSP_ADDR_INIT_CMD && shin_r == `SSP_INIT_KEY)
		begin
			init_r  <= 1'b1;
			setup_r <= `SSP_SETUP_RST;
		end
		else if (pd)
			init_r <= 1'b0;
		// Reads of both deltas, or a status write, clear the flag; new motion wins
		if (byte_end && state_r == ST_RDATA && addr_r == `SSP_ADDR_Y_DISP)
			rd_y_r <= 1'b1;
		if ((byte_end && state_r == ST_RDATA && addr_r == `SSP_ADDR_X_DISP) ||
		    (byte_end && state_r == ST_BURST && bytes_r == 3'd2))
			rd_x_r <= 1'b1;
		if (byte_end && state_r == ST_BURST && bytes_r == 3'd1)
			rd_y_r <= 1'b1;
		if (motion_event_i)
		begin
			mot_r  <= 1'b1;
			rd_y_r <= 1'b0;
			rd_x_r <= 1'b0;
		end
		else if ((rd_y_r && rd_x_r) || (wr_stb && addr_r == `SSP_ADDR_MOTION_STATUS))
		begin
			mot_r  <= 1'b0;
			rd_y_r <= 1'b0;
			rd_x_r <= 1'b0;
		end
		if (overflow_event_i)
			ovf_r <= 1'b1;
		else if (wr_stb && addr_r == `SSP_ADDR_MOTION_STATUS)
			ovf_r <= 1'b0;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Outputs

assign miso_o        = miso_r;
assign miso_oe_o     = active & (state_r == ST_RDATA || state_r == ST_BURST);
assign motion_n_o    = ~mot_r;
assign rest_mode_o   = setup_r[`SSP_REST_BIT];
assign initialised_o = init_r;
assign illum_drive_o = init_r & ~pd & ~setup_r[`SSP_REST_BIT];

endmodule

// [tb/ssp_props.sv]
// Concurrent checks on the ports of the serial port core
`timescale 1ns/1ps
module ssp_props
(
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// Serial pins
	input wire logic sclk_i,
	input wire logic port_select_n_i,
	input wire logic miso_o,
	input wire logic miso_oe_o,
	// Power-down and status
	input wire logic power_down_pin_i,
	input wire logic motion_event_i,
	input wire logic motion_n_o,
	input wire logic rest_mode_o,
	input wire logic initialised_o,
	input wire logic illum_drive_o
);
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (rst_i);
	////////////////////////////////////////////////////////////////////////
	sel_idle_a: assert property (port_select_n_i [*6] |-> !miso_oe_o)
		else $error("output driven while deselected");
	sel_abort_a: assert property ($rose(port_select_n_i) |-> ##[1:5] !miso_oe_o)
		else $error("output still driven after select rise");
	pd_idle_a: assert property (power_down_pin_i [*6] |-> !miso_oe_o)
		else $error("output driven in power-down");
	miso_hold_a: assert property (sclk_i [*4] ##0 ($past(miso_oe_o) && miso_oe_o)
		|-> $stable(miso_o))
		else $error("output bit changed while clock high");
	motion_set_a: assert property (motion_event_i |-> ##[1:3] !motion_n_o)
		else $error("motion pin not lowered");
	motion_win_a: assert property ($rose(motion_n_o) |-> !$past(motion_event_i))
		else $error("motion pin released during event");
	rest_dark_a: assert property (illum_drive_o |-> initialised_o && !rest_mode_o)
		else $error("illumination on in rest or before init");
	pd_uninit_a: assert property (power_down_pin_i [*5] |-> !initialised_o)
		else $error("still initialised in power-down");
	reset_state_a: assert property ($fell(rst_i) |->
		motion_n_o && !initialised_o && !miso_oe_o)
		else $error("wrong state after reset");
endmodule

bind ssp_core ssp_props props_u
(
	.clk_sys_i        (clk_sys_i),
	.rst_i            (rst_i),
	.sclk_i           (sclk_i),
	.port_select_n_i  (port_select_n_i),
	.miso_o           (miso_o),
	.miso_oe_o        (miso_oe_o),
	.power_down_pin_i (power_down_pin_i),
	.motion_event_i   (motion_event_i),
	.motion_n_o       (motion_n_o),
	.rest_mode_o      (rest_mode_o),
	.initialised_o    (initialised_o),
	.illum_drive_o    (illum_drive_o)
);

// [tb/ssp_host.sv]
// Host model that masters the serial port
`timescale 1ns/1ps
module ssp_host
(
	// Serial pins
	output logic sclk_o,
	output logic mosi_o,
	output logic sel_n_o,
	input  wire  miso_i,
	input  wire  miso_oe_i
);
	logic       oe_seen;
	logic [7:0] bq [0:6];
	initial
	begin
		sclk_o = 1'b1;
		mosi_o = 1'b0;
		sel_n_o = 1'b1;
		oe_seen = 1'b0;
	end
	// Released data line toggles while deselected
	always #40 if (sel_n_o) mosi_o = ~mosi_o;
	////////////////////////////////////////////////////////////////////////
	task xfer(input logic [7:0] tx, input integer nbit, output logic [7:0] rx);
		integer i;
		begin
			for (i = 7; i > 7 - nbit; i = i - 1)
			begin
				sclk_o = 1'b0;
				mosi_o = tx[i];
				#40;
				sclk_o = 1'b1;
				oe_seen = oe_seen | miso_oe_i;
				rx[i] = miso_oe_i ? miso_i : 1'bx;
				#40;
			end
		end
	endtask
	// Gap, address byte, delay, then nb data bytes back to back
	task frame(input logic [7:0] a, input logic [7:0] d, input integer nb,
		input integer nbit, input integer gap, output logic [7:0] rx);
		integer k;
		logic [7:0] junk;
		begin
			#gap;
			oe_seen = 1'b0;
			sel_n_o = 1'b0;
			#40;
			xfer(a, 8, junk);
			#400;
			for (k = 0; k < nb; k = k + 1)
				xfer(d, nbit, bq[k]);
			rx = bq[0];
			#40;
			sel_n_o = 1'b1;
		end
	endtask
endmodule

// [tb/testbench.sv]
// Self-checking bench of the serial port core
`timescale 1ns/1ps
module testbench;
	logic        clk_sys_i;
	logic        rst_i;
	logic        pd;
	logic        mev;
	logic [7:0]  rx;
	integer      num_errors;
	integer      tests_run;
	integer      cyc;
	integer      n;
	wire         sclk;
	wire         mosi;
	wire         sel_n;
	wire         miso;
	wire         miso_oe;
	wire         motion_n;
	wire         rest;
	wire         init;
	wire         illum;
	logic [7:0]  bx [0:6] = '{8'h80, 8'h12, 8'h34, 8'h5c, 8'h01, 8'h9e, 8'hc7};
	logic [23:0] rows [0:8] = '{24'h11_0003, 24'h91_8000, 24'h11_0003,
		24'hba_5a00, 24'h91_8000, 24'h11_0080, 24'h91_0300, 24'h20_0000, 24'h05_005c};
	////////////////////////////////////////////////////////////////////////
	ssp_host host_u
	(
		.sclk_o    (sclk),
		.mosi_o    (mosi),
		.sel_n_o   (sel_n),
		.miso_i    (miso),
		.miso_oe_i (miso_oe)
	);
	ssp_core dut_u
	(
		.clk_sys_i             (clk_sys_i),
		.rst_i                 (rst_i),
		.sclk_i                (sclk),
		.mosi_i                (mosi),
		.port_select_n_i       (sel_n),
		.miso_o                (miso),
		.miso_oe_o             (miso_oe),
		.power_down_pin_i      (pd),
		.motion_event_i        (mev),
		.overflow_event_i      (1'b0),
		.delta_y_i             (bx[1]),
		.delta_x_i             (bx[2]),
		.surface_quality_reg_i (bx[3]),
		.shutter_hi_i          (bx[4]),
		.shutter_lo_i          (bx[5]),
		.max_pixel_i           (bx[6]),
		.motion_n_o            (motion_n),
		.rest_mode_o           (rest),
		.initialised_o         (init),
		.illum_drive_o         (illum)
	);
	////////////////////////////////////////////////////////////////////////
	initial clk_sys_i = 1'b0;
	always #5 clk_sys_i = ~clk_sys_i;
	task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		begin
			tests_run = tests_run + 1;
			if (seen !== exp)
			begin
				num_errors = num_errors + 1;
				$display("unexpected %s expected %h seen %h", nm, exp, seen);
			end
		end
	endtask
	task wrap_up;
		begin
			if (num_errors == 0 && tests_run > 0)
				$display("verification passed");
			else
				$display("verification failed");
			$finish;
		end
	endtask
	task pulse;
		begin
			@(negedge clk_sys_i);
			mev = 1'b1;
			@(negedge clk_sys_i);
			mev = 1'b0;
			repeat (4) @(negedge clk_sys_i);
		end
	endtask
	always @(posedge clk_sys_i)
	begin
		cyc = cyc + 1;
		if (cyc == 20000)
		begin
			num_errors = num_errors + 1;
			wrap_up;
		end
	end
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		num_errors = 0;
		tests_run = 0;
		cyc = 0;
		rst_i = 1'b1;
		pd = 1'b0;
		mev = 1'b0;
		repeat (5) @(negedge clk_sys_i);
		rst_i = 1'b0;
		chk("init", init, 8'h00);
		chk("motion_n", motion_n, 8'h01);
		#100 host_u.sel_n_o = 1'b0;
		#100 host_u.sel_n_o = 1'b1;
		for (n = 0; n < 9; n = n + 1)
		begin
			host_u.frame(rows[n][23:16], rows[n][15:8], 1, 8, 600, rx);
			if (!rows[n][23])
				chk("read data", rx, rows[n][7:0]);
		end
		chk("illum", illum, 8'h01);
		host_u.frame(8'h91, 8'h80, 1, 8, 600, rx);
		#100 chk("rest", rest, 8'h01);
		chk("illum", illum, 8'h00);
		host_u.frame(8'h91, 8'h03, 1, 8, 600, rx);
		pulse;
		chk("motion_n", motion_n, 8'h00);
		for (n = 0; n < 3; n = n + 1)
		begin
			host_u.frame(8'h02 + n, 8'h00, 1, 8, 600, rx);
			chk("motion read", rx, bx[n]);
		end
		#100 chk("motion_n", motion_n, 8'h01);
		pulse;
		host_u.frame(8'h82, 8'h00, 1, 8, 600, rx);
		#100 chk("motion_n", motion_n, 8'h01);
		host_u.frame(8'h91, 8'h80, 1, 4, 600, rx);
		host_u.frame(8'h11, 8'h00, 1, 8, 600, rx);
		chk("after abort", rx, 8'h03);
		pulse;
		host_u.frame(8'h42, 8'h00, 7, 8, 600, rx);
		for (n = 0; n < 7; n = n + 1)
			chk("burst byte", host_u.bq[n], bx[n]);
		host_u.frame(8'h11, 8'h00, 1, 8, 100, rx);
		chk("refused oe", host_u.oe_seen, 8'h00);
		host_u.frame(8'h11, 8'h00, 1, 8, 600, rx);
		chk("after exit", rx, 8'h03);
		pulse;
		host_u.frame(8'h42, 8'h00, 3, 8, 600, rx);
		for (n = 0; n < 3; n = n + 1)
			chk("short burst", host_u.bq[n], bx[n]);
		host_u.frame(8'h11, 8'h00, 1, 8, 600, rx);
		chk("after short", rx, 8'h03);
		pulse;
		host_u.frame(8'h42, 8'h00, 3, 8, 600, rx);
		for (n = 0; n < 3; n = n + 1)
			chk("burst after short", host_u.bq[n], bx[n]);
		@(negedge clk_sys_i);
		pd = 1'b1;
		repeat (20) @(negedge clk_sys_i);
		chk("pd init", init, 8'h00);
		chk("pd illum", illum, 8'h00);
		pd = 1'b0;
		host_u.frame(8'hba, 8'h5a, 1, 8, 600, rx);
		#100 chk("reinit", init, 8'h01);
		wrap_up;
	end
endmodule
